/* File: lcdl_digit_decoder.sv */
// nibble to seven-segment pattern decoder
`timescale 1ns/1ns
`include "lcdl_params.svh"
module lcdl_digit_decoder (
  input  wire logic [3:0]             nibble,
  input  wire logic                   digit7_f,
  input  wire logic                   zero_blank,
  output logic      [`LCDL_BUS_W-1:0] pattern
);

  always_comb begin
    case (nibble) // R3
      4'h0:    pattern = zero_blank ? `LCDL_DIG_BLANK : `LCDL_DIG_0; // R5
      4'h1:    pattern = `LCDL_DIG_1;
      4'h2:    pattern = `LCDL_DIG_2;
      4'h3:    pattern = `LCDL_DIG_3;
      4'h4:    pattern = `LCDL_DIG_4;
      4'h5:    pattern = `LCDL_DIG_5;
      4'h6:    pattern = `LCDL_DIG_6;
      4'h7: begin
        pattern = `LCDL_DIG_7;
        pattern[`LCDL_DIG_7_F_BIT] = digit7_f; // R4
      end
      4'h8:    pattern = `LCDL_DIG_8;
      4'h9:    pattern = `LCDL_DIG_9;
      default: pattern = `LCDL_DIG_BLANK;
    endcase
  end

endmodule : lcdl_digit_decoder

/* File: lcdl_latch_path.sv */
// lcd pattern bus, strobe decode, pixel latches and pin drive
// Behaviour
// R1: dc output pins keep their level during stop mode and blanking
// R2: display commons run unbroken from common 1; only the rest may be dc
// R3: decoder maps digits 0..9 to fixed patterns, a..f give zeros
// R4: bit f of digit seven comes from a configuration input
// R5: blanking decode gives all zeros for a zero nibble
// R6: raw pair puts nibble on bits a..d, accumulator on e..h
// R7: table store puts table word bits 0..7 on bits a..h
// R8: six-bit latch address decodes to one of 64 strobes
// R9: 369 pixel latches, 41 segments by 9 commons, one bit each
// R10: each latch picks one bus bit and one strobe by configuration
// R11: blank turns all pixels off, unblank back on, latches untouched
// R12: stores still update latches while blanked
// R13: in stop mode all lcd-mode display pins are driven to ground
// R14: bulk stores write one of four 16-strobe groups
// R15: multiplexer scans commons for duty 1/2 up to 1/9
// R16: pin modes: common phase, push-pull dc or open-drain dc
// R17: segment pins 1..41, commons 5..9 usable as dc outputs
// R18: decode stores take register or index ram nibble alike
// R19: register operand addresses data memory at operand plus 70h
// R20: single register stores accept operand 0..7 only
// R21: dc pins drive their latch value as a static level
`timescale 1ns/1ns
`include "lcdl_params.svh"
module lcdl_latch_path (
  input  wire logic                        ref_clk,
  input  wire logic                        rst_n,
  input  wire logic                        instr_valid,
  input  wire lcdl_pkg::lcdl_op_t          instr_op,
  input  wire logic [5:0]                  latch_address,
  input  wire logic [1:0]                  bulk_group,
  input  wire logic                        src_is_ram,
  input  wire logic [3:0]                  work_reg_operand,
  input  wire logic [8:0]                  index_pointer,
  input  wire logic [3:0]                  src_nibble,
  input  wire logic [3:0]                  accumulator,
  input  wire logic [7:0]                  table_rom_word,
  input  wire logic                        stop_mode,
  input  wire logic [3:0]                  cfg_duty,
  input  wire logic                        cfg_digit7_f,
  input  wire logic [`LCDL_NUM_PIX*3-1:0]  cfg_pattern_bus_sel,
  input  wire logic [`LCDL_NUM_PIX*6-1:0]  cfg_strobe_sel,
  input  wire logic [`LCDL_NUM_SEG*2-1:0]  cfg_seg_mode,
  input  wire logic [`LCDL_NUM_COM*2-1:0]  cfg_com_mode,
  output logic      [`LCDL_BUS_W-1:0]      pattern_bus,
  output logic      [`LCDL_NUM_STB-1:0]    pixel_strobe,
  output logic      [8:0]                  mem_addr,
  output logic                             op_reject,
  output logic                             display_blanked,
  output logic      [`LCDL_NUM_PIX-1:0]    pixel_state,
  output logic      [`LCDL_NUM_SEG-1:0]    seg_out,
  output logic      [`LCDL_NUM_SEG-1:0]    seg_oe_n,
  output logic      [`LCDL_NUM_COM-1:0]    com_out,
  output logic      [`LCDL_NUM_COM-1:0]    com_oe_n
);

  lcdl_pkg::lcdl_state_t    state_reg;
  lcdl_pkg::lcdl_state_t    state_next;
  logic [`LCDL_BUS_W-1:0]   dec_pattern;
  logic                     zero_blank;
  logic                     is_single;
  logic                     is_bulk;
  logic                     uses_reg;
  logic                     reject_c;
  logic [`LCDL_BUS_W-1:0]   pattern_c;
  logic [`LCDL_NUM_STB-1:0] strobe_c;
  logic [`LCDL_NUM_PIX-1:0] cap;
  logic [`LCDL_NUM_PIX-1:0] cap_d;
  logic [`LCDL_NUM_SEG-1:0] seg_dc;
  logic [`LCDL_NUM_SEG-1:0] seg_od;
  logic [`LCDL_NUM_SEG-1:0] seg_dc_val;
  logic [`LCDL_NUM_SEG-1:0] seg_lcd_lvl;
  logic [`LCDL_NUM_COM-1:0] com_dc;
  logic [`LCDL_NUM_COM-1:0] com_od;
  logic [`LCDL_NUM_COM-1:0] com_dc_val;
  logic [`LCDL_NUM_COM-1:0] com_lcd_lvl;
  logic                     phase_wrap;

  ////////////////////////////////////////////////////////////////////////
  // pattern source

  assign zero_blank = (instr_op == lcdl_pkg::LCDL_BDEC) ||
                      (instr_op == lcdl_pkg::LCDL_XBDEC);

  lcdl_digit_decoder u_dec (
    .nibble     (src_nibble),
    .digit7_f   (cfg_digit7_f),
    .zero_blank (zero_blank),
    .pattern    (dec_pattern)
  );

  always_comb begin
    is_single = 1'b0;
    is_bulk   = 1'b0;
    uses_reg  = 1'b0;
    pattern_c = `LCDL_DIG_BLANK;
    case (instr_op)
      lcdl_pkg::LCDL_DEC, lcdl_pkg::LCDL_BDEC: begin
        is_single = 1'b1;
        uses_reg  = ~src_is_ram;
        pattern_c = dec_pattern; // R18
      end
      lcdl_pkg::LCDL_RAW: begin
        is_single = 1'b1;
        uses_reg  = ~src_is_ram;
        pattern_c = {accumulator, src_nibble}; // R6
      end
      lcdl_pkg::LCDL_TAB: begin
        is_single = 1'b1;
        pattern_c = table_rom_word; // R7
      end
      lcdl_pkg::LCDL_XDEC, lcdl_pkg::LCDL_XBDEC: begin
        is_bulk   = 1'b1;
        pattern_c = dec_pattern;
      end
      lcdl_pkg::LCDL_XRAW: begin
        is_bulk   = 1'b1;
        pattern_c = {accumulator, src_nibble}; // R6
      end
      lcdl_pkg::LCDL_XTAB: begin
        is_bulk   = 1'b1;
        pattern_c = table_rom_word; // R7
      end
      default: begin
        pattern_c = `LCDL_DIG_BLANK;
      end
    endcase
  end

  assign reject_c = instr_valid && uses_reg &&
                    (work_reg_operand > `LCDL_WREG_MAX); // R20

  always_comb begin
    strobe_c = '0;
    if (instr_valid && is_single && !reject_c) begin
      strobe_c = `LCDL_NUM_STB'(64'h1) << latch_address; // R8
    end else if (instr_valid && is_bulk) begin
      strobe_c = `LCDL_GROUP_MASK << {bulk_group, 4'h0}; // R14
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pixel latch array

  genvar i;
  generate
    for (i = 0; i < `LCDL_NUM_PIX; i = i + 1) begin : g_pix
      // R10
      assign cap[i]   = strobe_c[cfg_strobe_sel[i*`LCDL_STB_W +: 6]];
      assign cap_d[i] = pattern_c[cfg_pattern_bus_sel[i*`LCDL_SEL_W +: 3]];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // pin drive

  genvar s;
  generate
    for (s = 0; s < `LCDL_NUM_SEG; s = s + 1) begin : g_seg
      logic [`LCDL_NUM_COM-1:0] col;
      logic                     pix;
      assign col = state_reg.pixel[s*`LCDL_NUM_COM +: `LCDL_NUM_COM];
      assign pix = col[state_reg.phase];
      assign seg_dc[s] = cfg_seg_mode[2*s +: 2] != `LCDL_MODE_LCD; // R16 R17
      assign seg_od[s] = cfg_seg_mode[2*s +: 2] == `LCDL_MODE_OD;
      assign seg_dc_val[s] = col[0]; // R21
      assign seg_lcd_lvl[s] = stop_mode ? 1'b0 : // R13
        ((pix && !state_reg.blanked) ? state_reg.pol : ~state_reg.pol);
    end
    for (s = 0; s < `LCDL_NUM_COM; s = s + 1) begin : g_com
      logic allow_dc;
      assign allow_dc = (s >= `LCDL_COM_DC_FIRST) &&
                        (4'(s) >= cfg_duty); // R2
      assign com_dc[s] = allow_dc &&
                         (cfg_com_mode[2*s +: 2] != `LCDL_MODE_LCD); // R17
      assign com_od[s] = com_dc[s] &&
                         (cfg_com_mode[2*s +: 2] == `LCDL_MODE_OD); // R16
      assign com_dc_val[s] =
        state_reg.pixel[(`LCDL_NUM_SEG-1)*`LCDL_NUM_COM + s]; // R21
      assign com_lcd_lvl[s] = stop_mode ? 1'b0 : // R13
        ((state_reg.phase == 4'(s)) ? ~state_reg.pol : state_reg.pol);
    end
  endgenerate

  assign phase_wrap = (state_reg.phase >= cfg_duty - 4'h1);

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    state_next = state_reg;
    state_next.pixel = (state_reg.pixel & ~cap) | (cap_d & cap); // R9 R12
    state_next.strobe = strobe_c;
    state_next.pattern = pattern_c;
    state_next.reject = reject_c;
    if (instr_valid && (is_single || is_bulk) && !reject_c) begin // R20
      state_next.mem_addr = src_is_ram ? index_pointer :
        (`LCDL_WREG_BASE + {5'h00, work_reg_operand}); // R19
    end
    if (instr_valid && instr_op == lcdl_pkg::LCDL_BLANK) begin
      state_next.blanked = 1'b1; // R11
    end else if (instr_valid && instr_op == lcdl_pkg::LCDL_UNBLANK) begin
      state_next.blanked = 1'b0; // R11
    end
    if (state_reg.div >= `LCDL_SCAN_DIV - 8'h01) begin
      state_next.div = 8'h00;
      if (phase_wrap) begin
        state_next.phase = 4'h0; // R15
        state_next.pol = ~state_reg.pol;
      end else begin
        state_next.phase = state_reg.phase + 4'h1; // R15
      end
    end else begin
      state_next.div = state_reg.div + 8'h01;
    end
    // R1
    state_next.seg_out  = (seg_dc & seg_dc_val) | (~seg_dc & seg_lcd_lvl);
    state_next.seg_oe_n = seg_od & ~seg_dc_val;
    state_next.com_out  = (com_dc & com_dc_val) | (~com_dc & com_lcd_lvl);
    state_next.com_oe_n = com_od & ~com_dc_val;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign pattern_bus     = state_reg.pattern;
  assign pixel_strobe    = state_reg.strobe;
  assign mem_addr        = state_reg.mem_addr;
  assign op_reject       = state_reg.reject;
  assign display_blanked = state_reg.blanked;
  assign pixel_state     = state_reg.pixel;
  assign seg_out         = state_reg.seg_out;
  assign seg_oe_n        = state_reg.seg_oe_n;
  assign com_out         = state_reg.com_out;
  assign com_oe_n        = state_reg.com_oe_n;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  logic take;
  assign take = instr_valid && !reject_c;

  a_zero_blank: assert property ( // R5
    take && zero_blank && src_nibble == 4'h0 |=> pattern_bus == 8'h00)
    else $error("blanking decode of zero not all zeros");
  a_digit_seven: assert property ( // R4
    take && instr_op == lcdl_pkg::LCDL_DEC && src_nibble == 4'h7
    |=> pattern_bus == {2'b10, $past(cfg_digit7_f), 5'b00111})
    else $error("digit seven pattern wrong");
  a_raw_pair_map: assert property ( // R6
    take && instr_op == lcdl_pkg::LCDL_RAW
    |=> pattern_bus == {$past(accumulator), $past(src_nibble)})
    else $error("raw pair mapping wrong");
  a_table_map: assert property ( // R7
    take && instr_op == lcdl_pkg::LCDL_XTAB
    |=> pattern_bus == $past(table_rom_word))
    else $error("table mapping wrong");
  a_single_strobe: assert property ( // R8
    take && is_single
    |=> pixel_strobe == (64'h1 << $past(latch_address)))
    else $error("single strobe not one-hot at address");
  a_bulk_group: assert property ( // R14
    instr_valid && is_bulk
    |=> pixel_strobe == (64'hffff << {$past(bulk_group), 4'h0}))
    else $error("bulk strobe group wrong");
  a_operand_reject: assert property ( // R20
    instr_valid && uses_reg && work_reg_operand > 4'h7
    |=> op_reject && pixel_strobe == '0 && $stable(pixel_state) &&
    $stable(mem_addr))
    else $error("out of range operand not refused");
  a_mem_addr_reg: assert property ( // R19
    take && is_single && !src_is_ram
    |=> mem_addr == 9'h070 + {5'h00, $past(work_reg_operand)})
    else $error("register memory address wrong");
  a_blank_keeps: assert property ( // R11
    instr_valid && (instr_op == lcdl_pkg::LCDL_BLANK ||
    instr_op == lcdl_pkg::LCDL_UNBLANK) |=> $stable(pixel_state))
    else $error("blank changed latch contents");
  a_stop_ground: assert property ( // R13
    stop_mode |=> (seg_out & ~$past(seg_dc)) == '0 &&
    (com_out & ~$past(com_dc)) == '0)
    else $error("display pin not grounded in stop mode");
  a_dc_static: assert property ( // R1
    ##1 ((seg_out ^ $past(seg_dc_val)) & $past(seg_dc)) == '0)
    else $error("dc segment pin lost its level");
  a_phase_range: assert property ( // R15
    cfg_duty >= 4'h2 && cfg_duty <= 4'h9 && $stable(cfg_duty)[*2]
    |-> state_reg.phase < cfg_duty)
    else $error("common phase beyond duty");

  c_blank_store: cover property (
    display_blanked && take && is_single ##1 pixel_strobe != '0);
  c_bulk_store: cover property (instr_valid && is_bulk);
  c_unblank: cover property (
    display_blanked ##1 instr_valid && instr_op == lcdl_pkg::LCDL_UNBLANK);
  c_stop: cover property (stop_mode[*3]);

endmodule : lcdl_latch_path

/* File: lcdl_panel_model.sv */
// passive glass panel model resolving pin drive into line levels
`timescale 1ns/1ns
module lcdl_panel_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic [40:0] seg_out,
  input  wire logic [40:0] seg_oe_n,
  input  wire logic [8:0]  com_out,
  input  wire logic [8:0]  com_oe_n,
  output logic      [40:0] seg_line,
  output logic      [8:0]  com_line
);
  logic [40:0] seg_keep;
  logic [8:0]  com_keep;
  ////////////////////////////////////////////////////////////////////////////
  // last level seen on each line
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seg_keep <= '0;
      com_keep <= '0;
    end else begin
      seg_keep <= seg_line;
      com_keep <= com_line;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // no pull on the glass: a released line drifts every cycle
  always_comb begin
    for (int s = 0; s < 41; s++) begin
      seg_line[s] = seg_oe_n[s] ? ~seg_keep[s] : seg_out[s];
    end
    for (int c = 0; c < 9; c++) begin
      com_line[c] = com_oe_n[c] ? ~com_keep[c] : com_out[c];
    end
  end
endmodule : lcdl_panel_model

/* File: lcdl_params.svh */
// constants of the lcd pattern latch path
`ifndef LCDL_PARAMS_SVH
`define LCDL_PARAMS_SVH

`define LCDL_NUM_SEG      41
`define LCDL_NUM_COM      9
`define LCDL_NUM_PIX      369
`define LCDL_NUM_STB      64
`define LCDL_BUS_W        8
`define LCDL_SEL_W        3
`define LCDL_STB_W        6
`define LCDL_GROUP_MASK   64'h000000000000ffff
`define LCDL_WREG_BASE    9'h070
`define LCDL_WREG_MAX     4'h7
`define LCDL_COM_DC_FIRST 4
`define LCDL_SCAN_DIV     8'h10

`define LCDL_DIG_0        8'hbf
`define LCDL_DIG_1        8'h86
`define LCDL_DIG_2        8'hdb
`define LCDL_DIG_3        8'hcf
`define LCDL_DIG_4        8'he6
`define LCDL_DIG_5        8'hed
`define LCDL_DIG_6        8'hfd
`define LCDL_DIG_7        8'h87
`define LCDL_DIG_7_F_BIT  5
`define LCDL_DIG_8        8'hff
`define LCDL_DIG_9        8'hef
`define LCDL_DIG_BLANK    8'h00

`define LCDL_OP_NOP       4'h0
`define LCDL_OP_DEC       4'h1
`define LCDL_OP_BDEC      4'h2
`define LCDL_OP_RAW       4'h3
`define LCDL_OP_TAB       4'h4
`define LCDL_OP_XDEC      4'h5
`define LCDL_OP_XBDEC     4'h6
`define LCDL_OP_XRAW      4'h7
`define LCDL_OP_XTAB      4'h8
`define LCDL_OP_BLANK     4'h9
`define LCDL_OP_UNBLANK   4'ha

`define LCDL_MODE_LCD     2'h0
`define LCDL_MODE_PP      2'h1
`define LCDL_MODE_OD      2'h2

`endif

/* File: lcdl_pkg.sv */
// types of the lcd pattern latch path
`include "lcdl_params.svh"
package lcdl_pkg;

  typedef enum logic [3:0] {
    LCDL_NOP      = `LCDL_OP_NOP,
    LCDL_DEC      = `LCDL_OP_DEC,
    LCDL_BDEC     = `LCDL_OP_BDEC,
    LCDL_RAW      = `LCDL_OP_RAW,
    LCDL_TAB      = `LCDL_OP_TAB,
    LCDL_XDEC     = `LCDL_OP_XDEC,
    LCDL_XBDEC    = `LCDL_OP_XBDEC,
    LCDL_XRAW     = `LCDL_OP_XRAW,
    LCDL_XTAB     = `LCDL_OP_XTAB,
    LCDL_BLANK    = `LCDL_OP_BLANK,
    LCDL_UNBLANK  = `LCDL_OP_UNBLANK
  } lcdl_op_t;

  typedef enum logic [1:0] {
    LCDL_PIN_LCD = `LCDL_MODE_LCD,
    LCDL_PIN_PP  = `LCDL_MODE_PP,
    LCDL_PIN_OD  = `LCDL_MODE_OD
  } lcdl_pin_mode_t;

  typedef struct packed {
    logic [`LCDL_NUM_PIX-1:0] pixel;
    logic                     blanked;
    logic                     pol;
    logic [3:0]               phase;
    logic [7:0]               div;
    logic [`LCDL_NUM_STB-1:0] strobe;
    logic [`LCDL_BUS_W-1:0]   pattern;
    logic [8:0]               mem_addr;
    logic                     reject;
    logic [`LCDL_NUM_SEG-1:0] seg_out;
    logic [`LCDL_NUM_SEG-1:0] seg_oe_n;
    logic [`LCDL_NUM_COM-1:0] com_out;
    logic [`LCDL_NUM_COM-1:0] com_oe_n;
  } lcdl_state_t;

endpackage : lcdl_pkg

/* File: lcdl_tb.sv */
// self-checking bench of the lcd pattern latch path
`timescale 1ns/1ns
`include "lcdl_params.svh"
module tb;
  logic                ref_clk;
  logic                rst_n;
  logic                instr_valid;
  lcdl_pkg::lcdl_op_t  instr_op;
  logic [5:0]          latch_address;
  logic [1:0]          bulk_group;
  logic                src_is_ram;
  logic [3:0]          work_reg_operand;
  logic [8:0]          index_pointer;
  logic [3:0]          src_nibble;
  logic [3:0]          accumulator;
  logic [7:0]          table_rom_word;
  logic                stop_mode;
  logic [3:0]          cfg_duty;
  logic                cfg_digit7_f;
  logic [1106:0]       cfg_pattern_bus_sel;
  logic [2213:0]       cfg_strobe_sel;
  logic [81:0]         cfg_seg_mode;
  logic [17:0]         cfg_com_mode;
  logic [7:0]          pattern_bus;
  logic [63:0]         pixel_strobe;
  logic [8:0]          mem_addr;
  logic                op_reject;
  logic                display_blanked;
  logic [368:0]        pixel_state;
  logic [40:0]         seg_out;
  logic [40:0]         seg_oe_n;
  logic [8:0]          com_out;
  logic [8:0]          com_oe_n;
  logic [40:0]         seg_line;
  logic [8:0]          com_line;
  logic [368:0]        shadow = '0;
  int                  errors = 0;
  int                  comparisons = 0;
  int                  cycles = 0;
  // digit patterns written a..h from left
  logic [7:0] dig [10] = '{8'b11111101, 8'b01100001, 8'b11011011,
    8'b11110011, 8'b01100111, 8'b10110111, 8'b10111111, 8'b11100001,
    8'b11111111, 8'b11110111};

  lcdl_latch_path dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .instr_valid(instr_valid), .instr_op(instr_op),
    .latch_address(latch_address), .bulk_group(bulk_group),
    .src_is_ram(src_is_ram), .work_reg_operand(work_reg_operand),
    .index_pointer(index_pointer), .src_nibble(src_nibble),
    .accumulator(accumulator), .table_rom_word(table_rom_word),
    .stop_mode(stop_mode), .cfg_duty(cfg_duty),
    .cfg_digit7_f(cfg_digit7_f), .cfg_pattern_bus_sel(cfg_pattern_bus_sel),
    .cfg_strobe_sel(cfg_strobe_sel), .cfg_seg_mode(cfg_seg_mode),
    .cfg_com_mode(cfg_com_mode), .pattern_bus(pattern_bus),
    .pixel_strobe(pixel_strobe), .mem_addr(mem_addr),
    .op_reject(op_reject), .display_blanked(display_blanked),
    .pixel_state(pixel_state), .seg_out(seg_out), .seg_oe_n(seg_oe_n),
    .com_out(com_out), .com_oe_n(com_oe_n));

  lcdl_panel_model panel (.ref_clk(ref_clk), .rst_n(rst_n),
    .seg_out(seg_out), .seg_oe_n(seg_oe_n), .com_out(com_out),
    .com_oe_n(com_oe_n), .seg_line(seg_line), .com_line(com_line));
  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [7:0] rev(input logic [7:0] v);
    for (int k = 0; k < 8; k++) rev[k] = v[7-k];
  endfunction : rev

  task automatic chk(input logic [368:0] seen, input logic [368:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop

  // one instruction, then strobe, pattern and latch contents judged
  task automatic st(input lcdl_pkg::lcdl_op_t op, input logic [5:0] a,
    input logic [3:0] nib, input logic [3:0] ac, input logic [7:0] tw,
    input logic [7:0] ep, input logic rej);
    logic [63:0] stb;
    @(posedge ref_clk);
    instr_valid    <= 1'b1;
    instr_op       <= op;
    latch_address  <= a;
    bulk_group     <= a[5:4];
    src_nibble     <= nib;
    accumulator    <= ac;
    table_rom_word <= tw;
    @(posedge ref_clk);
    instr_valid <= 1'b0;
    #1;
    stb = 64'h1 << a;
    if (op inside {lcdl_pkg::LCDL_XDEC, lcdl_pkg::LCDL_XBDEC,
                   lcdl_pkg::LCDL_XRAW, lcdl_pkg::LCDL_XTAB})
      stb = 64'hffff << {a[5:4], 4'h0};
    if (rej || op inside {lcdl_pkg::LCDL_BLANK, lcdl_pkg::LCDL_UNBLANK})
      stb = 64'h0;
    chk(op_reject, rej);
    chk(pixel_strobe, stb);
    if (!rej) chk(pattern_bus, ep);
    for (int i = 0; i < 369; i++)
      if (stb[cfg_strobe_sel[6*i+:6]]) shadow[i] = ep[cfg_pattern_bus_sel[3*i+:3]];
    chk(pixel_state, shadow);
  endtask : st
  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_decode;
    logic [7:0] e;
    src_is_ram    <= 1'b1;
    index_pointer <= 9'h1a5;
    for (int f = 0; f < 2; f++) begin
      cfg_digit7_f <= f[0];
      for (int n = 0; n < 16; n++) begin
        e = (n > 9) ? 8'h00 : rev(dig[n]);
        if (n == 7) e[5] = f[0];
        st(lcdl_pkg::LCDL_DEC, {1'b0, f[0], n[3:0]}, n[3:0], 4'h0, 8'h00,
           e, 1'b0);
      end
    end
    chk(mem_addr, 9'h1a5);
  endtask : t_decode

  task automatic t_codes;
    st(lcdl_pkg::LCDL_BDEC, 6'h20, 4'h0, 4'h0, 8'h00, 8'h00, 1'b0);
    st(lcdl_pkg::LCDL_BDEC, 6'h21, 4'h9, 4'h0, 8'h00, rev(dig[9]), 1'b0);
    st(lcdl_pkg::LCDL_RAW, 6'h2a, 4'h5, 4'ha, 8'h00, 8'ha5, 1'b0);
    st(lcdl_pkg::LCDL_TAB, 6'h3f, 4'h0, 4'h0, 8'h3c, 8'h3c, 1'b0);
    for (int g = 0; g < 4; g++) begin
      st(lcdl_pkg::LCDL_XDEC, {g[1:0], 4'h0}, 4'h8, 4'h0, 8'h00, 8'hff, 1'b0);
      st(lcdl_pkg::LCDL_XBDEC, {g[1:0], 4'h0}, 4'h0, 4'h0, 8'h00, 8'h00, 1'b0);
      st(lcdl_pkg::LCDL_XTAB, {g[1:0], 4'h0}, 4'h0, 4'h0, 8'h5a, 8'h5a, 1'b0);
      st(lcdl_pkg::LCDL_XRAW, {g[1:0], 4'h0}, 4'h3, 4'hc, 8'h00, 8'hc3, 1'b0);
    end
  endtask : t_codes

  task automatic t_reject;
    logic [8:0] m;
    lcdl_pkg::lcdl_op_t ops [3];
    ops = '{lcdl_pkg::LCDL_DEC, lcdl_pkg::LCDL_BDEC, lcdl_pkg::LCDL_RAW};
    m = mem_addr;
    src_is_ram       <= 1'b0;
    work_reg_operand <= 4'h8;
    foreach (ops[k]) begin
      st(ops[k], 6'h11, 4'h6, 4'h1, 8'h00, 8'h00, 1'b1);
      chk(mem_addr, m);
    end
    st(lcdl_pkg::LCDL_XTAB, 6'h30, 4'h0, 4'h0, 8'h96, 8'h96, 1'b0);
    work_reg_operand <= 4'h7;
    st(lcdl_pkg::LCDL_DEC, 6'h11, 4'h6, 4'h0, 8'h00, rev(dig[6]), 1'b0);
    chk(mem_addr, 9'h077);
  endtask : t_reject

  task automatic t_blank;
    logic pol;
    st(lcdl_pkg::LCDL_BLANK, 6'h00, 4'h0, 4'h0, 8'h00, 8'h00, 1'b0);
    chk(display_blanked, 1'b1);
    st(lcdl_pkg::LCDL_TAB, 6'h00, 4'h0, 4'h0, 8'hff, 8'hff, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    pol = ($countones(com_out[4:0]) > 2);
    chk(seg_out[40:2], {39{~pol}});
    chk(seg_out[0], shadow[0]);
    st(lcdl_pkg::LCDL_UNBLANK, 6'h00, 4'h0, 4'h0, 8'h00, 8'h00, 1'b0);
    chk(display_blanked, 1'b0);
  endtask : t_blank

  task automatic t_stop;
    stop_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    chk({seg_out[40:2], com_out[4:0]}, '0);
    chk({seg_oe_n[40:2], com_oe_n[4:0]}, '0);
    chk({seg_line[40:2], com_line[4:0]}, '0);
    chk(seg_out[0], shadow[0]);
    chk({seg_out[1], seg_oe_n[1]}, {shadow[9], ~shadow[9]});
    chk(com_out[8:5], shadow[368:365]);
    stop_mode <= 1'b0;
  endtask : t_stop

  task automatic t_scan;
    int hits [5];
    int bad;
    logic [4:0] x;
    hits = '{0, 0, 0, 0, 0};
    bad = 0;
    repeat (160) begin
      @(posedge ref_clk);
      #1;
      x = com_out[4:0];
      if ($countones(x) > 2) x = ~x;
      if ($onehot(x)) hits[$clog2(x)]++;
      else bad++;
      if (seg_out[0] !== shadow[0] ||
          com_out[8:5] !== shadow[368:365]) bad++;
    end
    chk(bad, 0);
    foreach (hits[c]) chk(hits[c], 32);
  endtask : t_scan
  ////////////////////////////////////////////////////////////////////////////
  // clock, timeout and main sequence
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      report_and_stop;
    end
  end

  initial begin
    rst_n            = 1'b0;
    instr_valid      = 1'b0;
    instr_op         = lcdl_pkg::LCDL_NOP;
    latch_address    = 6'h00;
    bulk_group       = 2'h0;
    src_is_ram       = 1'b1;
    work_reg_operand = 4'h0;
    index_pointer    = 9'h000;
    src_nibble       = 4'h0;
    accumulator      = 4'h0;
    table_rom_word   = 8'h00;
    stop_mode        = 1'b0;
    cfg_duty         = 4'h5;
    cfg_digit7_f     = 1'b0;
    cfg_seg_mode     = {78'h0, 4'h9};
    cfg_com_mode     = 18'h15500;
    for (int i = 0; i < 369; i++) begin
      cfg_pattern_bus_sel[3*i+:3]   = i[2:0];
      cfg_strobe_sel[6*i+:6] = i[5:0];
    end
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    #1;
    chk(pixel_state, shadow);
    t_decode;
    t_codes;
    t_reject;
    t_blank;
    t_stop;
    t_scan;
    report_and_stop;
  end
endmodule : tb
